// ### ebpm_assertions.sv
// Purpose: port-level checks of the pin mux top
// Assumes: one clock, sync active-low reset
// Notes: pin checks skip the first cycle after reset, when pins still hold reset values
module ebpm_assertions #(
	parameter int ADDR_BITS = 26,
	parameter int NCS = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic [ADDR_BITS-1:0] smc_addr,
	input wire logic [NCS-1:0] smc_ncs_n,
	input wire logic smc_busy,
	input wire logic [12:0] sdc_addr,
	input wire logic sdc_cs_n,
	input wire logic sdc_active,
	input wire logic [ADDR_BITS-1:0] ebi_addr,
	input wire logic dram_addr10_pin,
	input wire logic [NCS-1:0] ebi_ncs_n,
	input wire logic chip_sel3_pin,
	input wire logic [1:0] card_cs_n,
	input wire logic cs1_route_sel,
	input wire logic cs3_nand_enable,
	input wire logic cs4_card_slot_a_enable,
	input wire logic cs5_card_slot_b_enable,
	input wire logic data_pullup_en,
	input wire ebpm_pkg::ebpm_drive_e pad_drive_sel
);
	logic live_q;
	// one cycle of grace after reset release
	always_ff @(posedge aclk)
		live_q <= aresetn;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_ans;
		s_axi_rvalid && !s_axi_arready;
	endsequence
	property p_rd;
		s_rd_take |=> s_rd_ans;
	endproperty
	property p_cs1;
		live_q && $stable(cs1_route_sel) |->
			ebi_ncs_n[1] == (cs1_route_sel ? $past(sdc_cs_n) : $past(smc_ncs_n[1]));
	endproperty
	property p_nand;
		live_q && $stable(cs3_nand_enable) |->
			chip_sel3_pin == ($past(smc_ncs_n[3]) | !cs3_nand_enable);
	endproperty
	property p_card;
		live_q && $stable({cs5_card_slot_b_enable, cs4_card_slot_a_enable}) |->
			card_cs_n == ($past(smc_ncs_n[5:4]) | ~{cs5_card_slot_b_enable, cs4_card_slot_a_enable});
	endproperty
	property p_pullup;
		live_q && $changed(data_pullup_en) |-> $past(s_axi_bvalid);
	endproperty
	property p_drive;
		live_q && $changed(pad_drive_sel) |-> $past(s_axi_bvalid);
	endproperty
	property p_dram_addr;
		live_q && cs1_route_sel && $stable(cs1_route_sel) && $past(sdc_active) |->
			{ebi_addr[14:13], dram_addr10_pin, ebi_addr[11:2]} == $past(sdc_addr);
	endproperty
	property p_static_addr;
		live_q |-> (ebi_addr & 26'h3ff_9003) == ($past(smc_addr) & 26'h3ff_9003);
	endproperty
	property p_ncs;
		live_q |-> (ebi_ncs_n | 8'h02) == ($past(smc_ncs_n) | 8'h02);
	endproperty
	property p_idle;
		live_q && $changed({cs1_route_sel, cs3_nand_enable, cs4_card_slot_a_enable}) |->
			!$past(smc_busy, 2) && !$past(sdc_active, 2);
	endproperty
	a_rd: assert property (p_rd)
		else $error("read not answered");
	a_cs1: assert property (p_cs1)
		else $error("chip select 1 owner wrong");
	a_nand: assert property (p_nand)
		else $error("nand select wrong");
	a_card: assert property (p_card)
		else $error("card select wrong");
	a_pullup: assert property (p_pullup)
		else $error("pull-up moved without a write");
	a_drive: assert property (p_drive)
		else $error("drive moved without a write");
	a_dram_addr: assert property (p_dram_addr)
		else $error("dram address steering wrong");
	a_static_addr: assert property (p_static_addr)
		else $error("static-only address pins wrong");
	a_ncs: assert property (p_ncs)
		else $error("chip select pins wrong");
	a_idle: assert property (p_idle)
		else $error("routing applied while busy");
endmodule

bind ebpm_top ebpm_assertions #(.ADDR_BITS(ADDR_BITS), .NCS(NCS)) chk_u (.*);

// ### ebpm_axil.sv
// Purpose: AXI4-Lite slave front end handing single register accesses to the core
// Assumes: one write and one read outstanding at most
// Notes: address and data may arrive in either order; response one cycle after both
`include "ebpm_cfg.svh"

module ebpm_axil #(
	parameter int AW = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [AW-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic [AW-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);

	logic [AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	// ready low means the item is held here until the response is taken
	assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_addr = awaddr_q;
	assign wr_data = wdata_q;
	assign wr_strb = wstrb_q;
	assign rd_addr = s_axi_araddr;

	// write address and data capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `EBPM_RESP_OKAY;
		end else if (wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `EBPM_RESP_OKAY : `EBPM_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read channel; data sampled at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `EBPM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_ok ? `EBPM_RESP_OKAY : `EBPM_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// ### ebpm_cfg.svh
// Purpose: constants for the external bus pin mux and its chip-select assignment register
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: byte offsets; reserved bits read as zero
// Contract
// - cs1 route bit 0 gives chip select 1 to static ctrl, 1 to dram ctrl.
// - cs3 bit 0 plain static select; 1 keeps static select and enables nand logic.
// - cs4 bit 1 enables first card slot logic; 0 plain static select.
// - cs5 bit 1 enables second card slot logic; 0 plain static select.
// - pull-up bit 0 enables data pull-ups on d0..d15; 1 disables them.
// - pad drive code 00 low 1.8V, 01 low 3.3V, 10 high 1.8V, 11 high 3.3V.
// - pins a2..a11 carry dram a0..a9, a13..a14 dram a11..a12 when dram active and cs1 routed to dram.
// - pins a0, a1, a12, a15..a25 static only; dedicated pin carries dram a10.
// - 16 or 32-bit data path, 26 address bits, eight chip selects.
`ifndef EBPM_CFG_SVH
`define EBPM_CFG_SVH

`define EBPM_CSA_OFFSET 12'h11C
`define EBPM_BUSCFG_OFFSET 12'h120
`define EBPM_STATUS_OFFSET 12'h124
`define EBPM_CSA_RESET 32'h0001_0000
`define EBPM_CSA_MASK 32'h0003_013A
`define EBPM_BUSCFG_RESET 32'h0000_0001
`define EBPM_BUSCFG_MASK 32'h0000_0001
`define EBPM_CS1_BIT 1
`define EBPM_CS3_BIT 3
`define EBPM_CS4_BIT 4
`define EBPM_CS5_BIT 5
`define EBPM_PULLUP_BIT 8
`define EBPM_DRIVE_LSB 16
`define EBPM_DRIVE_MSB 17
`define EBPM_WIDE_BIT 0
`define EBPM_BUSY_BIT 8
`define EBPM_RESP_OKAY 2'h0
`define EBPM_RESP_SLVERR 2'h2

`endif

// ### ebpm_ext_mem.sv
// Purpose: behavioural external memory on chip select 0 with pad pull-ups
// Assumes: memory answers whenever selected and the device is not driving
// Notes: released lines toggle unless pulled up (d0..d15 with pull-ups on), so a stale value never passes for data
module ebpm_ext_mem (
	input wire logic aclk,
	input wire logic [7:0] ebi_ncs_n,
	input wire logic [25:0] ebi_addr,
	input wire logic [31:0] ebi_d_drv,
	input wire logic [31:0] ebi_d_oe,
	input wire logic data_pullup_en,
	output logic [31:0] ebi_d_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] last_q = '0;
	// remember the wire so a released line can show its inverse
	always_ff @(posedge aclk)
		last_q <= ebi_d_pin;
	// wire level: device first, then selected memory, then pull-up or float
	always_comb
		for (int i = 0; i < 32; i++)
			if (ebi_d_oe[i])
				ebi_d_pin[i] = ebi_d_drv[i];
			else if (!ebi_ncs_n[0])
				ebi_d_pin[i] = ebi_addr[i % 16] ^ (i < 16);
			else if (i < 16 && data_pullup_en)
				ebi_d_pin[i] = 1'b1;
			else
				ebi_d_pin[i] = ~last_q[i];
endmodule

// ### ebpm_pin_mux.sv
// Purpose: combinational steering of controller signals onto the shared bus pins
// Assumes: applied configuration only changes between accesses
// Notes: outputs are registered by the caller
module ebpm_pin_mux (
	input wire logic owner_dram,
	input wire logic cs1_dram,
	input wire logic nand_en,
	input wire logic [1:0] card_en,
	input wire logic wide_bus,
	input wire logic [25:0] smc_addr,
	input wire logic [7:0] smc_ncs_n,
	input wire logic [31:0] smc_d,
	input wire logic smc_d_oe,
	input wire logic [12:0] sdc_addr,
	input wire logic sdc_cs_n,
	input wire logic [31:0] sdc_d,
	input wire logic sdc_d_oe,
	output logic [25:0] pin_addr,
	output logic pin_a10,
	output logic [7:0] pin_ncs_n,
	output logic pin_nand_cs_n,
	output logic [1:0] pin_card_cs_n,
	output logic [31:0] pin_d,
	output logic [31:0] pin_d_oe
);

	logic oe;

	// address steering
	always_comb begin
		pin_addr = smc_addr;
		pin_a10 = 1'b0;
		if (owner_dram) begin
			pin_addr[11:2] = sdc_addr[9:0];
			pin_addr[14:13] = sdc_addr[12:11];
			pin_a10 = sdc_addr[10];
		end
	end

	// chip selects; nand and card selects are copies gated by their enables
	always_comb begin
		pin_ncs_n = smc_ncs_n;
		pin_ncs_n[1] = cs1_dram ? sdc_cs_n : smc_ncs_n[1];
		pin_nand_cs_n = nand_en ? smc_ncs_n[3] : 1'b1;
		pin_card_cs_n[0] = card_en[0] ? smc_ncs_n[4] : 1'b1;
		pin_card_cs_n[1] = card_en[1] ? smc_ncs_n[5] : 1'b1;
	end

	// data drive; upper half stays off in 16-bit mode
	always_comb begin
		oe = owner_dram ? sdc_d_oe : smc_d_oe;
		pin_d = owner_dram ? sdc_d : smc_d;
		pin_d_oe = {{16{oe && wide_bus}}, {16{oe}}};
	end

endmodule

// ### ebpm_pkg.sv
// Purpose: shared types of the external bus pin mux
// Assumes: nothing beyond the cfg header
// Notes: pad drive codes follow the register field encoding
package ebpm_pkg;

	typedef enum logic [1:0] {
		EBPM_DRV_LOW_1V8 = 2'h0,
		EBPM_DRV_LOW_3V3 = 2'h1,
		EBPM_DRV_HIGH_1V8 = 2'h2,
		EBPM_DRV_HIGH_3V3 = 2'h3
	} ebpm_drive_e;

	typedef enum logic {
		EBPM_OWN_STATIC,
		EBPM_OWN_DRAM
	} ebpm_owner_e;

endpackage

// ### ebpm_top.sv
// Purpose: chip-select assignment register and shared pin multiplexer of the external bus
// Assumes: controllers run on aclk; data pins are asynchronous and synchronised here
// Notes: routing fields take effect only while both controllers are idle
`include "ebpm_cfg.svh"

module ebpm_top #(
	parameter int ADDR_BITS = 26,
	parameter int NCS = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [ADDR_BITS-1:0] smc_addr,
	input wire logic [NCS-1:0] smc_ncs_n,
	input wire logic smc_busy,
	input wire logic [31:0] smc_d,
	input wire logic smc_d_oe,
	input wire logic [12:0] sdc_addr,
	input wire logic sdc_cs_n,
	input wire logic sdc_active,
	input wire logic [31:0] sdc_d,
	input wire logic sdc_d_oe,
	input wire logic [31:0] ebi_d_pin,
	output logic [ADDR_BITS-1:0] ebi_addr,
	output logic dram_addr10_pin,
	output logic [NCS-1:0] ebi_ncs_n,
	output logic chip_sel3_pin,
	output logic [1:0] card_cs_n,
	output logic [31:0] ebi_d_drv,
	output logic [31:0] ebi_d_oe,
	output logic [31:0] ctrl_rd_data,
	output logic cs1_route_sel,
	output logic cs3_nand_enable,
	output logic cs4_card_slot_a_enable,
	output logic cs5_card_slot_b_enable,
	output logic data_pullup_en,
	output ebpm_pkg::ebpm_drive_e pad_drive_sel,
	output logic data_bus_wide
);

	// merge a byte-enabled write into a register, touching only defined bits
	function automatic logic [31:0] merge_wr(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] be;
		be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~(be & mask)) | (data & be & mask);
	endfunction

	// pad flops start at the register's reset field values, so no code change follows reset
	localparam logic [31:0] CSA_RST = `EBPM_CSA_RESET;

	logic wr_en;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic [11:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;

	logic [31:0] csa_q;
	logic [31:0] buscfg_q;
	logic cs1_act_q;
	logic cs3_act_q;
	logic cs4_act_q;
	logic cs5_act_q;
	logic wide_act_q;
	logic bus_idle;
	logic owner_dram;
	logic [31:0] d_meta_q;

	logic [25:0] mux_addr;
	logic mux_a10;
	logic [7:0] mux_ncs_n;
	logic mux_nand_cs_n;
	logic [1:0] mux_card_cs_n;
	logic [31:0] mux_d;
	logic [31:0] mux_d_oe;

	ebpm_axil #(
		.AW(12)
	) u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	// address decode; the status word is read only, so writing it is refused
	function automatic logic wr_ok_rd(input logic [11:0] a);
		return (a == `EBPM_CSA_OFFSET) || (a == `EBPM_BUSCFG_OFFSET) ||
			(a == `EBPM_STATUS_OFFSET);
	endfunction

	assign wr_ok = (wr_addr == `EBPM_CSA_OFFSET) || (wr_addr == `EBPM_BUSCFG_OFFSET);
	assign rd_ok = wr_ok_rd(rd_addr);

	// read mux; unmapped addresses answer zero with an error response
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (rd_addr)
			`EBPM_CSA_OFFSET: rd_data = csa_q;
			`EBPM_BUSCFG_OFFSET: rd_data = buscfg_q;
			`EBPM_STATUS_OFFSET: begin
				rd_data[`EBPM_CS1_BIT] = cs1_act_q;
				rd_data[`EBPM_CS3_BIT] = cs3_act_q;
				rd_data[`EBPM_CS4_BIT] = cs4_act_q;
				rd_data[`EBPM_CS5_BIT] = cs5_act_q;
				rd_data[`EBPM_BUSY_BIT] = !bus_idle;
			end
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// chip-select assignment register; undefined bits are masked off on write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			csa_q <= `EBPM_CSA_RESET;
		end else if (wr_en && wr_addr == `EBPM_CSA_OFFSET) begin
			csa_q <= merge_wr(csa_q, wr_data, wr_strb, `EBPM_CSA_MASK);
		end
	end

	// bus width configuration word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buscfg_q <= `EBPM_BUSCFG_RESET;
		end else if (wr_en && wr_addr == `EBPM_BUSCFG_OFFSET) begin
			buscfg_q <= merge_wr(buscfg_q, wr_data, wr_strb, `EBPM_BUSCFG_MASK);
		end
	end

	// routing is copied only between accesses, so a select never changes owner mid-cycle
	assign bus_idle = !smc_busy && !sdc_active;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cs1_act_q <= 1'b0;
			cs3_act_q <= 1'b0;
			cs4_act_q <= 1'b0;
			cs5_act_q <= 1'b0;
			wide_act_q <= 1'b1;
		end else if (bus_idle) begin
			cs1_act_q <= csa_q[`EBPM_CS1_BIT];
			cs3_act_q <= csa_q[`EBPM_CS3_BIT];
			cs4_act_q <= csa_q[`EBPM_CS4_BIT];
			cs5_act_q <= csa_q[`EBPM_CS5_BIT];
			wide_act_q <= buscfg_q[`EBPM_WIDE_BIT];
		end
	end

	// the dram controller owns the shared pins only when select 1 is routed to it
	assign owner_dram = cs1_act_q && sdc_active;

	ebpm_pin_mux u_mux (
		.owner_dram(owner_dram),
		.cs1_dram(cs1_act_q),
		.nand_en(cs3_act_q),
		.card_en({cs5_act_q, cs4_act_q}),
		.wide_bus(wide_act_q),
		.smc_addr(smc_addr[25:0]),
		.smc_ncs_n(smc_ncs_n[7:0]),
		.smc_d(smc_d),
		.smc_d_oe(smc_d_oe),
		.sdc_addr(sdc_addr),
		.sdc_cs_n(sdc_cs_n),
		.sdc_d(sdc_d),
		.sdc_d_oe(sdc_d_oe),
		.pin_addr(mux_addr),
		.pin_a10(mux_a10),
		.pin_ncs_n(mux_ncs_n),
		.pin_nand_cs_n(mux_nand_cs_n),
		.pin_card_cs_n(mux_card_cs_n),
		.pin_d(mux_d),
		.pin_d_oe(mux_d_oe)
	);

	// pin registers; one cycle of latency from controller to pad
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ebi_addr <= '0;
			dram_addr10_pin <= 1'b0;
			ebi_ncs_n <= '1;
			chip_sel3_pin <= 1'b1;
			card_cs_n <= 2'h3;
		end else begin
			ebi_addr <= mux_addr[ADDR_BITS-1:0];
			dram_addr10_pin <= mux_a10;
			ebi_ncs_n <= mux_ncs_n[NCS-1:0];
			chip_sel3_pin <= mux_nand_cs_n;
			card_cs_n <= mux_card_cs_n;
		end
	end

	// data drive registers; enables low in reset so the pads float
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ebi_d_drv <= '0;
			ebi_d_oe <= '0;
		end else begin
			ebi_d_drv <= mux_d;
			ebi_d_oe <= mux_d_oe;
		end
	end

	// read data from the pads crosses in from outside, so two stages first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			d_meta_q <= '0;
			ctrl_rd_data <= '0;
		end else begin
			d_meta_q <= ebi_d_pin;
			ctrl_rd_data <= d_meta_q;
		end
	end

	// pad configuration follows the register directly; it does not affect ownership
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_pullup_en <= !CSA_RST[`EBPM_PULLUP_BIT];
			pad_drive_sel <= ebpm_pkg::ebpm_drive_e'(CSA_RST[`EBPM_DRIVE_MSB:`EBPM_DRIVE_LSB]);
		end else begin
			data_pullup_en <= !csa_q[`EBPM_PULLUP_BIT];
			pad_drive_sel <= ebpm_pkg::ebpm_drive_e'(csa_q[`EBPM_DRIVE_MSB:`EBPM_DRIVE_LSB]);
		end
	end

	// applied mode flags for the controllers and pad logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cs1_route_sel <= 1'b0;
			cs3_nand_enable <= 1'b0;
			cs4_card_slot_a_enable <= 1'b0;
			cs5_card_slot_b_enable <= 1'b0;
			data_bus_wide <= 1'b1;
		end else begin
			cs1_route_sel <= cs1_act_q;
			cs3_nand_enable <= cs3_act_q;
			cs4_card_slot_a_enable <= cs4_act_q;
			cs5_card_slot_b_enable <= cs5_act_q;
			data_bus_wide <= wide_act_q;
		end
	end

endmodule

// ### external_bus_pin_mux_config_bench.sv
// Purpose: self-checking bench of the external bus pin mux config block
// Assumes: writes land while both controllers idle unless a case says otherwise
// Notes: cycle timing of pins is left to the bound checker
`include "ebpm_cfg.svh"
module external_bus_pin_mux_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0;
	logic aresetn = 0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, ebi_d_pin, ebi_d_drv, ebi_d_oe, ctrl_rd_data;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, card_cs_n;
	logic [25:0] smc_addr = '0, ebi_addr;
	logic [7:0] smc_ncs_n = 8'hff, ebi_ncs_n;
	logic smc_busy = 0, sdc_cs_n = 1, sdc_active = 0;
	logic [12:0] sdc_addr = '0;
	logic [31:0] smc_d = '0, sdc_d = '0;
	logic smc_d_oe = 0, sdc_d_oe = 0;
	logic dram_addr10_pin, chip_sel3_pin, cs1_route_sel, cs3_nand_enable, cs4_card_slot_a_enable;
	logic cs5_card_slot_b_enable, data_pullup_en, data_bus_wide;
	ebpm_pkg::ebpm_drive_e pad_drive_sel;
	logic [31:0] csa_q = 32'h0001_0000;
	int bad_count = 0;
	int n_tests = 0;
	ebpm_top dut_u (.*);
	ebpm_ext_mem mem_u (.*);
	// system clock
	always #5 aclk = ~aclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// register image after a strobed write; reserved bits stay zero
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			if (s[i])
				o[8*i +: 8] = d[8*i +: 8];
		return o & `EBPM_CSA_MASK;
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		bit aw, w;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		aw = 0;
		w = 0;
		while (!(aw && w)) begin
			@(posedge aclk);
			aw |= s_axi_awready;
			w |= s_axi_wready;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk(s_axi_bresp, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, r);
	endtask
	// hang guard, well above the few hundred cycles the run needs
	initial begin
		repeat (6000) @(posedge aclk);
		bad_count++;
		wrap_up();
	end
	// main sequence
	initial begin
		logic [31:0] v;
		logic [3:0] s;
		logic [31:0] d;
		void'($urandom(32'hdd49));
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rd(`EBPM_CSA_OFFSET, 32'h0001_0000, `EBPM_RESP_OKAY);
		rd(12'h110, 32'h0, `EBPM_RESP_SLVERR);
		wr(12'h200, 32'hffff_ffff, 4'hf, `EBPM_RESP_SLVERR);
		// every drive code; the last write strobes only the low and drive bytes
		for (int c = 0; c < 4; c++) begin
			v = $urandom;
			v[17:16] = c[1:0];
			s = (c == 3) ? 4'h5 : 4'hf;
			wr(`EBPM_CSA_OFFSET, v, s, `EBPM_RESP_OKAY);
			csa_q = merge(csa_q, v, s);
			repeat (4) @(posedge aclk);
			chk(pad_drive_sel, csa_q[17:16]);
			chk(data_pullup_en, !csa_q[8]);
			chk({cs5_card_slot_b_enable, cs4_card_slot_a_enable, cs3_nand_enable, cs1_route_sel},
				{csa_q[5:3], csa_q[1]});
			rd(`EBPM_CSA_OFFSET, csa_q, `EBPM_RESP_OKAY);
		end
		// routing written while the dram side is busy waits for idle
		csa_q = csa_q & ~32'h0000_0002;
		wr(`EBPM_CSA_OFFSET, csa_q, 4'hf, `EBPM_RESP_OKAY);
		repeat (4) @(posedge aclk);
		sdc_active <= 1;
		csa_q = csa_q | 32'h0000_0002;
		wr(`EBPM_CSA_OFFSET, csa_q, 4'hf, `EBPM_RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk(cs1_route_sel, 1'b0);
		sdc_active <= 0;
		repeat (4) @(posedge aclk);
		chk(cs1_route_sel, 1'b1);
		sdc_active <= 1;
		sdc_cs_n <= 0;
		sdc_addr <= 13'h1abc;
		smc_addr <= 26'h3ff_ffff;
		repeat (3) @(posedge aclk);
		chk({ebi_addr[14:13], dram_addr10_pin, ebi_addr[11:2]}, 13'h1abc);
		chk({ebi_addr[25:15], ebi_addr[12], ebi_addr[1:0]}, 14'h3fff);
		chk(ebi_ncs_n, 8'hfd);
		// random controller traffic for the checker
		repeat (300) begin
			@(posedge aclk);
			smc_addr <= 26'($urandom);
			smc_ncs_n <= 8'($urandom);
			sdc_addr <= 13'($urandom);
			sdc_cs_n <= 1'($urandom);
			sdc_active <= 1'($urandom);
			smc_busy <= 1'($urandom);
		end
		smc_busy <= 0;
		sdc_active <= 0;
		smc_ncs_n <= 8'hfe;
		smc_addr <= 26'h12_3456;
		repeat (5) @(posedge aclk);
		chk(ctrl_rd_data, {16'h3456, ~16'h3456});
		smc_ncs_n <= 8'hff;
		csa_q = csa_q & ~32'h0000_0100;
		wr(`EBPM_CSA_OFFSET, csa_q, 4'hf, `EBPM_RESP_OKAY);
		repeat (5) @(posedge aclk);
		chk(ctrl_rd_data[15:0], 16'hffff);
		@(posedge aclk);
		chk(ctrl_rd_data[15:0], 16'hffff);
		// data drive in both widths and from both controllers
		rd(`EBPM_BUSCFG_OFFSET, 32'h0000_0001, `EBPM_RESP_OKAY);
		wr(`EBPM_STATUS_OFFSET, 32'hffff_ffff, 4'hf, `EBPM_RESP_SLVERR);
		rd(`EBPM_STATUS_OFFSET, csa_q & 32'h0000_003a, `EBPM_RESP_OKAY);
		d = $urandom;
		smc_d <= d;
		smc_d_oe <= 1;
		repeat (4) @(posedge aclk);
		chk(ebi_d_oe, 32'hffff_ffff);
		chk(ebi_d_drv, d);
		chk(ctrl_rd_data, d);
		wr(`EBPM_BUSCFG_OFFSET, 32'h0000_0000, 4'hf, `EBPM_RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk(data_bus_wide, 1'b0);
		chk(ebi_d_oe, 32'h0000_ffff);
		smc_d_oe <= 0;
		sdc_d <= ~d;
		sdc_d_oe <= 1;
		sdc_active <= 1;
		repeat (3) @(posedge aclk);
		chk(ebi_d_drv, ~d);
		chk(ebi_d_oe, 32'h0000_ffff);
		sdc_active <= 0;
		wrap_up();
	end
endmodule
